/* File: hsg_cfg.svh */
// Purpose: constants for the supply guard and fire control register bank
// Assumes: byte-wide register port, 8-bit supply reading
// Notes: offsets are register addresses on the device register port
`ifndef HSG_CFG_SVH
`define HSG_CFG_SVH

// register addresses
`define HSG_ADDR_GUARD_CFG 8'h09
`define HSG_ADDR_TIER1 8'h0A
`define HSG_ADDR_TIER2 8'h0B
`define HSG_ADDR_FIRE 8'h0C
// reset values
`define HSG_RST_GUARD_CFG 8'h00
`define HSG_RST_TIER1 8'h92
`define HSG_RST_TIER2 8'h8D
`define HSG_RST_FIRE 8'h00
`define HSG_RST_FIRE_BIT 1'b0
`define HSG_RST_UV 1'b0
`define HSG_RST_RD 8'h00
// read data for unmapped addresses and the padding above the fire bit
`define HSG_RD_UNMAPPED 8'h00
`define HSG_FIRE_PAD 7'h00
// field positions
`define HSG_LVL_HI 7
`define HSG_LVL_LO 6
`define HSG_UV_HI 2
`define HSG_UV_LO 0
`define HSG_FIRE_BIT 0
// tier enable codes
`define HSG_LVL_OFF 2'h0
`define HSG_LVL_T1 2'h1
`define HSG_LVL_T12 2'h2
// undervoltage trip: base 2.5 V, 0.1 V per code, in millivolts
`define HSG_UV_BASE_MV 12'h9C4
`define HSG_UV_STEP_MV 12'h064
// process select codes
`define HSG_MODE_PLAY 2'h1
`define HSG_MODE_CAL 2'h2
`define HSG_MODE_DIAG 2'h3
// clamp select codes
`define HSG_CLAMP_NORM 2'h0
`define HSG_CLAMP_T1 2'h1
`define HSG_CLAMP_T2 2'h2

`endif

/* File: hsg_pkg.sv */
// Purpose: types for the supply guard and fire control register bank
// Assumes: nothing beyond the constants header
// Notes: states and grouped signals
package hsg_pkg;

  typedef enum logic [1:0] {
    HSG_IDLE = 2'b00,
    HSG_RUN = 2'b01
  } hsg_state_type;

  // register write request
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hsg_wr_type;

  // process launch command
  typedef struct packed {
    logic start_play;
    logic start_cal;
    logic start_diag;
    logic abort;
  } hsg_launch_type;

endpackage

/* File: hsg_guard_fire.sv */
// Purpose: supply guard configuration, tier thresholds and process fire control
// Assumes: the I2C slave turns host accesses into byte-wide register requests
// Notes: launched processes live outside; they report completion with proc_done
// Notes: the three configuration bytes share one small register module
`timescale 1ns/1ps
`default_nettype none
`include "hsg_cfg.svh"

// Functional notes
// R1 - Guard level select 0 disables tiers, 1 enables tier one, 2 enables both tiers.
// R2 - Undervoltage trip code 0 to 7 selects 2.5 V to 3.2 V in 0.1 V steps.
// R3 - Supply below the trip level shuts the output stage at once and forces standby.
// R4 - With tier one enabled, supply below the tier-one threshold selects the tier-one clamp.
// R5 - With tier two enabled, supply below the tier-two threshold selects the tier-two clamp.
// R6 - Supply is sampled for tiers only at effect start and the clamp holds for the effect.
// R7 - Host should program the tier-one limit at or above the tier-two limit.
// R8 - Host should program the tier-one threshold above the tier-two threshold.
// R9 - Setting the fire bit starts the process that the mode selects.
// R10 - In playback mode firing plays the sequencer slots as a software trigger.
// R11 - Firing also launches calibration or diagnostics when the mode selects them.
// R12 - The fire bit reads 1 while the process runs and clears itself on completion.
// R13 - Writing 0 to the fire bit during playback aborts it immediately.
// R14 - An external trigger sets the fire bit and starts the process like a write.
module hsg_guard_fire
  import hsg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire hsg_wr_type wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  // process control
  input wire logic [1:0] mode,
  input wire logic hw_trigger,
  input wire logic proc_done,
  output hsg_launch_type launch,
  output logic fire_active,
  // supply monitor
  input wire logic [7:0] supply_level,
  input wire logic [11:0] supply_mv,
  output logic [1:0] clamp_select,
  output logic [11:0] uv_trip_mv,
  output logic output_stage_off,
  output logic force_standby
);

  // sequencing state
  hsg_state_type state_q, state_d;
  logic fire_q, fire_d;
  logic [1:0] clamp_q, clamp_d;
  // configuration registers and their next values
  logic [7:0] guard_cfg_q, guard_cfg_d;
  logic [7:0] tier1_q, tier1_d;
  logic [7:0] tier2_q, tier2_d;
  // registered read data
  logic [7:0] rd_data_q, rd_data_d;
  // decoded trip level and the held undervoltage flag
  logic [11:0] uv_mv_q, uv_mv_d;
  logic uv_q, uv_d;
  // decoded fields and request strobes
  logic [1:0] level_sel;
  logic [2:0] uv_code;
  logic fire_wr, fire_wr_set, fire_wr_clr, start, uv_trip;

  assign level_sel = guard_cfg_q[`HSG_LVL_HI:`HSG_LVL_LO];
  assign uv_code = guard_cfg_q[`HSG_UV_HI:`HSG_UV_LO];
  assign fire_wr = wr.we && (wr.addr == `HSG_ADDR_FIRE);
  assign fire_wr_set = fire_wr && wr.wdata[`HSG_FIRE_BIT];
  assign fire_wr_clr = fire_wr && !wr.wdata[`HSG_FIRE_BIT];
  // compare is combinational so the output stage drops in the same cycle
  assign uv_trip = supply_mv < uv_mv_q; // [R3]
  // a request seen while idle launches unless supply is under the trip level; requests while running are ignored
  assign start = (state_q == HSG_IDLE) && !uv_trip && (fire_wr_set || hw_trigger); // [R9] [R14]

  // guard configuration: level select and trip code; unmapped writes fall through
  hsg_cfg_byte #(
    .ADDR(`HSG_ADDR_GUARD_CFG),
    .RST(`HSG_RST_GUARD_CFG)
  ) u_guard_cfg (
    .clk(clk),
    .srst(srst),
    .wr(wr),
    .value_d(guard_cfg_d),
    .value_q(guard_cfg_q)
  ); // [R1] [R2]

  // tier-one supply threshold
  hsg_cfg_byte #(
    .ADDR(`HSG_ADDR_TIER1),
    .RST(`HSG_RST_TIER1)
  ) u_tier1 (
    .clk(clk),
    .srst(srst),
    .wr(wr),
    .value_d(tier1_d),
    .value_q(tier1_q)
  ); // [R4]

  // tier-two supply threshold
  hsg_cfg_byte #(
    .ADDR(`HSG_ADDR_TIER2),
    .RST(`HSG_RST_TIER2)
  ) u_tier2 (
    .clk(clk),
    .srst(srst),
    .wr(wr),
    .value_d(tier2_d),
    .value_q(tier2_q)
  ); // [R5]

  // undervoltage trip level decode
  always_comb
  begin
    uv_mv_d = `HSG_UV_BASE_MV + 12'(`HSG_UV_STEP_MV * {9'h000, uv_code}); // [R2]
  end

  // trip level register; the compare uses it two cycles after a code write request
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      uv_mv_q <= `HSG_UV_BASE_MV;
    end
    else
    begin
      uv_mv_q <= uv_mv_d;
    end
  end

  // undervoltage seen this cycle, held one more so a short dip still drops the stage
  always_comb
  begin
    uv_d = uv_trip; // [R3]
  end

  // undervoltage flag register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      uv_q <= `HSG_RST_UV;
    end
    else
    begin
      uv_q <= uv_d;
    end
  end

  // fire bit and process sequencing
  always_comb
  begin
    state_d = state_q;
    fire_d = fire_q;
    clamp_d = clamp_q;
    launch = '0;
    case (state_q)
      HSG_IDLE:
      begin
        if (start)
        begin
          state_d = HSG_RUN;
          fire_d = 1'b1; // [R12] [R14]
          // mode is decoded only here, so a later change cannot retarget a run
          launch.start_play = (mode == `HSG_MODE_PLAY); // [R10]
          launch.start_cal = (mode == `HSG_MODE_CAL); // [R11]
          launch.start_diag = (mode == `HSG_MODE_DIAG); // [R11]
          // supply sampled once here and held for the whole effect
          clamp_d = `HSG_CLAMP_NORM; // [R6]
          if ((level_sel == `HSG_LVL_T12) && (supply_level < tier2_q))
            clamp_d = `HSG_CLAMP_T2; // [R5] [R1]
          else if (((level_sel == `HSG_LVL_T1) || (level_sel == `HSG_LVL_T12))
                   && (supply_level < tier1_q))
            clamp_d = `HSG_CLAMP_T1; // [R4] [R1]
        end
      end
      HSG_RUN:
      begin
        if (uv_trip)
        begin
          // undervoltage cancels whatever runs
          launch.abort = 1'b1; // [R3]
          state_d = HSG_IDLE;
          fire_d = 1'b0;
        end
        else if (fire_wr_clr)
        begin
          launch.abort = 1'b1; // [R13]
          state_d = HSG_IDLE;
          fire_d = 1'b0;
        end
        else if (proc_done)
        begin
          state_d = HSG_IDLE;
          fire_d = 1'b0; // [R12]
        end
      end
      default:
      begin
        state_d = HSG_IDLE;
        fire_d = 1'b0;
      end
    endcase
  end

  // register read mux
  always_comb
  begin
    case (rd_addr)
      `HSG_ADDR_GUARD_CFG: rd_data_d = guard_cfg_d;
      `HSG_ADDR_TIER1: rd_data_d = tier1_d;
      `HSG_ADDR_TIER2: rd_data_d = tier2_d;
      `HSG_ADDR_FIRE: rd_data_d = {`HSG_FIRE_PAD, fire_d}; // [R12]
      default: rd_data_d = `HSG_RD_UNMAPPED;
    endcase
  end

  // sequencing registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= HSG_IDLE;
      fire_q <= `HSG_RST_FIRE_BIT;
      clamp_q <= `HSG_CLAMP_NORM;
    end
    else
    begin
      state_q <= state_d;
      fire_q <= fire_d;
      clamp_q <= clamp_d;
    end
  end

  // read data register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_data_q <= `HSG_RST_RD;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end

  // outputs
  assign rd_data = rd_data_q;
  assign fire_active = fire_q;
  assign clamp_select = clamp_q;
  assign uv_trip_mv = uv_mv_q;
  assign output_stage_off = uv_trip || uv_q; // [R3]
  assign force_standby = uv_trip || uv_q; // [R3]

endmodule // hsg_guard_fire

// one byte-wide configuration register with its own address decode
module hsg_cfg_byte
  import hsg_pkg::*;
#(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [7:0] RST = 8'h00
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire hsg_wr_type wr,
  // next and current value; the next value feeds the read mux
  output logic [7:0] value_d,
  output logic [7:0] value_q
);

  logic [7:0] val_q, val_d;

  // a write to this address replaces the whole byte
  always_comb
  begin
    val_d = val_q;
    if (wr.we && (wr.addr == ADDR))
    begin
      val_d = wr.wdata;
    end
  end

  // value register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      val_q <= RST;
    end
    else
    begin
      val_q <= val_d;
    end
  end

  // outputs
  assign value_d = val_d;
  assign value_q = val_q;

endmodule // hsg_cfg_byte
`default_nettype wire

/* File: hsg_guard_fire_assertions.sv */
// Purpose: port checks for hsg_guard_fire
// Assumes: one clock, srst synchronous active high
// Notes: bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module hsg_guard_fire_assertions
  import hsg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // watched ports
  input wire hsg_wr_type wr,
  input wire logic [1:0] mode,
  input wire logic hw_trigger,
  input wire logic proc_done,
  input wire hsg_launch_type launch,
  input wire logic fire_active,
  input wire logic [1:0] clamp_select,
  input wire logic [11:0] supply_mv,
  input wire logic [11:0] uv_trip_mv,
  input wire logic output_stage_off,
  input wire logic force_standby
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // fire requests that must be taken
  wire fw = wr.we && wr.addr == 8'h0C;
  wire req = !fire_active && !output_stage_off && (fw && wr.wdata[0] || hw_trigger);
  sequence s_abort;
    launch.abort ##1 !fire_active;
  endsequence
  a_fire_sets: assert property (req |=> fire_active)
    else $error("fire bit not set");
  a_proc_select: assert property (req && mode != 2'h0 |->
    {launch.start_play, launch.start_cal, launch.start_diag} == (3'b100 >> (mode - 2'h1)))
    else $error("wrong process launched");
  a_done_clears: assert property (fire_active && proc_done && !fw |=> !fire_active)
    else $error("fire bit not cleared");
  a_fire_holds: assert property (
    fire_active && !proc_done && !fw && !output_stage_off |=> fire_active)
    else $error("fire bit dropped");
  a_abort_now: assert property (fire_active && fw && !wr.wdata[0] |-> s_abort)
    else $error("abort missing");
  a_uv_off: assert property (supply_mv < uv_trip_mv |-> output_stage_off && force_standby)
    else $error("stage not off");
  a_trip_code: assert property (wr.we && wr.addr == 8'h09 |-> ##2
    uv_trip_mv == 12'h9C4 + 12'h064 * $past(wr.wdata[2:0], 2))
    else $error("trip level wrong");
  a_clamp_held: assert property (fire_active && $past(fire_active) |-> $stable(clamp_select))
    else $error("clamp changed");
endmodule // hsg_guard_fire_assertions
bind hsg_guard_fire hsg_guard_fire_assertions u_chk (.clk, .srst, .wr, .mode, .hw_trigger,
  .proc_done, .launch, .fire_active, .clamp_select, .supply_mv, .uv_trip_mv,
  .output_stage_off, .force_standby);
`default_nettype wire

/* File: hsg_proc_model.sv */
// Purpose: stand-in for the processes launched by the fire bit
// Assumes: done_delay is at least 1
// Notes: done_delay sets how long each process runs
`timescale 1ns/1ps
`default_nettype none
module hsg_proc_model
  import hsg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // process side
  input wire hsg_launch_type launch,
  input wire logic [7:0] done_delay,
  output logic proc_done
);
  logic [7:0] cnt_q;
  // count a running process down; abort drops it without completion
  always_ff @(posedge clk)
  begin
    if (srst || launch.abort)
      cnt_q <= 8'h00;
    else if (launch.start_play | launch.start_cal | launch.start_diag)
      cnt_q <= done_delay;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  assign proc_done = cnt_q == 8'h01;
endmodule // hsg_proc_model
`default_nettype wire

/* File: test_haptic_supply_guard_and_fire.sv */
// Purpose: self-checking bench for hsg_guard_fire
// Assumes: process model answers after dly cycles
// Notes: tier one threshold kept above tier two
`timescale 1ns/1ps
`default_nettype none
module test_haptic_supply_guard_and_fire;
  import hsg_pkg::*;
  // stimulus and observed signals
  logic clk = 1'b0, srst = 1'b1, hw_trigger = 1'b0, proc_done, fire_active, stage_off, standby;
  logic [1:0] mode = 2'h1, clamp_select;
  logic [7:0] rd_addr = 8'h00, rd_data, supply_level = 8'hFF, dly = 8'h08;
  logic [11:0] supply_mv = 12'hFFF, uv_trip_mv;
  hsg_wr_type wr = '0;
  hsg_launch_type launch;
  int num_errors = 0, checks_done = 0, cyc = 0;
  always #5 clk = ~clk;
  hsg_guard_fire DUT (.clk, .srst, .wr, .rd_addr, .rd_data, .mode, .hw_trigger, .proc_done,
    .launch, .fire_active, .supply_level, .supply_mv, .clamp_select, .uv_trip_mv,
    .output_stage_off(stage_off), .force_standby(standby));
  hsg_proc_model PM (.clk, .srst, .launch, .done_delay(dly), .proc_done);
  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    checks_done++;
    if (e !== g)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // register port cycles, both end 1 ns after an edge
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= '{1'b1, a, d};
    @(posedge clk);
    wr.we <= 1'b0;
    #1;
  endtask
  task automatic rreg(logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_addr <= a;
    @(posedge clk);
    #1 d = rd_data;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 60 && fire_active === 1'b1; i++)
      #10;
    chk("fire done", 1'b0, fire_active);
  endtask
  // reset values and an unmapped read
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] ex [5] = '{8'h00, 8'h92, 8'h8D, 8'h00, 8'h00};
    chk("trip reset", 12'h9C4, uv_trip_mv);
    for (int i = 0; i < 5; i++)
    begin
      rreg(8'h09 + 8'(i), d);
      chk("reg reset", ex[i], d);
    end
  endtask
  // each trip code, then supply one millivolt under it
  task automatic t_trip;
    logic [11:0] e;
    for (int c = 0; c < 8; c++)
    begin
      e = 12'h9C4 + 12'h064 * 12'(c);
      wreg(8'h09, 8'(c));
      #10 chk("trip mv", e, uv_trip_mv);
      @(posedge clk);
      supply_mv <= e - 12'h001;
      #1 chk("stage off", 1'b1, stage_off & standby);
      @(posedge clk);
      supply_mv <= 12'hFFF;
    end
  endtask
  // tier codes against two readings; clamp held while supply moves
  task automatic t_tiers;
    logic [7:0] cf [5] = '{8'h00, 8'h40, 8'h40, 8'h80, 8'h80};
    logic [7:0] lv [5] = '{8'h80, 8'h90, 8'h80, 8'h90, 8'h80};
    logic [1:0] ex [5] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2};
    // overdrive limits stay with the host; nothing here sets tier two above tier one
    wreg(8'h0B, 8'h88);
    for (int i = 0; i < 5; i++)
    begin
      wreg(8'h09, cf[i]);
      supply_level <= lv[i];
      wreg(8'h0C, 8'h01);
      chk("clamp", ex[i], clamp_select);
      supply_level <= 8'h00;
      #20 chk("clamp held", ex[i], clamp_select);
      wait_idle;
      supply_level <= 8'hFF;
    end
  endtask
  // every process code reads back set until completion
  task automatic t_modes;
    logic [7:0] d;
    for (int m = 1; m < 4; m++)
    begin
      mode <= 2'(m);
      wreg(8'h0C, 8'h01);
      rreg(8'h0C, d);
      chk("fire readback", 8'h01, d);
      wait_idle;
    end
  endtask
  // abort a long playback, then fire from the trigger pin
  task automatic t_abort;
    dly <= 8'h40;
    mode <= 2'h1;
    wreg(8'h0C, 8'h01);
    wreg(8'h0C, 8'h00);
    chk("aborted", 1'b0, fire_active);
    dly <= 8'h04;
    @(posedge clk);
    hw_trigger <= 1'b1;
    @(posedge clk);
    hw_trigger <= 1'b0;
    #1 chk("trigger fire", 1'b1, fire_active);
    wait_idle;
  endtask
  // cycle ceiling
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      report_and_stop;
    end
  end
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    t_regs;
    t_trip;
    t_tiers;
    t_modes;
    t_abort;
    report_and_stop;
  end
endmodule // test_haptic_supply_guard_and_fire
`default_nettype wire
